// ===== logic/amstc_top.sv
`timescale 1ns/1ns
module amstc_top
  import amstc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Access request
  input  wire logic              acc_req_i,
  input  wire amstc_req_s        acc_i,
  output logic                   acc_busy_o,
  output logic                   acc_done_o,
  output logic                   acc_err_o,
  // Memory pins
  input  wire logic              memory_ready_in_i,
  output logic                   mem_cs_n_o,
  output logic                   mem_oe_n_o,
  output logic                   mem_we_n_o,
  output logic                   mem_wide_o
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  logic ready;

  amstc_in_sync u_ready_sync (
    .clk_i   (clk_i),
    .nrst_i  (rst_n_q),
    .pin_i   (memory_ready_in_i),
    .level_o (ready)
  );

  // ****************************************************************
  // Period helpers
  // ****************************************************************
  function automatic logic [5:0] setup_len(input logic [3:0] v,
                                           input logic       first);
    logic [5:0] len;
    len = (v <= SETUP_FLOOR) ? MIN_PERIOD : {2'h0, v};
    if (first && (len < FIRST_SETUP)) begin
      len = FIRST_SETUP;
    end
    return len;
  endfunction

  function automatic logic [5:0] strobe_len(input logic [5:0] v);
    return (v <= STROBE_FLOOR) ? MIN_PERIOD : v;
  endfunction

  // ****************************************************************
  // Control registers
  // ****************************************************************
  amstc_ctl1_s ctl1_q [NUM_SPACES];
  amstc_ctl2_s ctl2_q [NUM_SPACES];
  amstc_ctl3_s ctl3_q [NUM_SPACES];

  logic [SPACE_W-1:0] wr_space;
  logic               wr_space_hit;

  assign wr_space     = reg_addr_i[3:2];
  assign wr_space_hit = reg_wr_i && !reg_addr_i[4];

  for (genvar s = 0; s < NUM_SPACES; s++) begin : g_space
    always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
        ctl1_q[s] <= RST_TYPE_READ;
        ctl2_q[s] <= RST_WRITE;
        ctl3_q[s] <= RST_TIMEOUT; // RULE_15
      end else if (wr_space_hit && (wr_space == SPACE_W'(s))) begin
        if (reg_addr_i[1:0] == OFS_TYPE_READ) begin
          ctl1_q[s] <= {1'b0, reg_wdata_i[14:0]}; // RULE_01
        end else if (reg_addr_i[1:0] == OFS_WRITE) begin
          ctl2_q[s] <= reg_wdata_i;
        end else if (reg_addr_i[1:0] == OFS_TIMEOUT) begin
          ctl3_q[s] <= {8'h00, reg_wdata_i[7:0]}; // RULE_14
        end
      end
    end
  end

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  amstc_state_e state_q;
  amstc_state_e state_d;
  logic [5:0]   cnt_q;
  logic [5:0]   cnt_d;
  logic         ext_q;
  logic         ext_d;
  logic         write_q;
  logic [SPACE_W-1:0] space_q;
  amstc_ctl1_s  cur1_q;
  amstc_ctl2_s  cur2_q;
  logic [7:0]   limit_q;
  logic         start;
  logic         refuse_wr8;
  logic         refuse_kind;
  logic         finish;
  logic         tmo_hit;
  logic         tmo_seen_q;
  logic [7:0]   tmo_cnt_q;
  logic [1:0]   hold_raw;
  logic [1:0]   exh_raw;
  logic [5:0]   hold_len;
  amstc_ctl1_s  sel1;
  amstc_ctl2_s  sel2;

  assign sel1     = ctl1_q[acc_i.space];
  assign sel2     = ctl2_q[acc_i.space];
  assign hold_raw = write_q ? cur2_q.write_hold_cycles
                            : cur1_q.read_hold_cycles;
  assign exh_raw  = write_q ? cur2_q.write_extra_hold_cycles
                            : cur2_q.read_extra_hold_cycles;

  // A stretched strobe never leaves a zero hold behind it.
  always_comb begin
    hold_len = {4'h0, hold_raw}; // RULE_06 RULE_13
    if ((hold_raw == 2'h0) && (ext_q || tmo_hit)) begin
      hold_len = MIN_PERIOD; // RULE_07 RULE_08
    end
  end

  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    ext_d       = ext_q;
    start       = 1'b0;
    refuse_wr8  = 1'b0;
    refuse_kind = 1'b0;
    finish      = 1'b0;
    case (state_q)
      ST_IDLE: begin
        ext_d = 1'b0;
        if (acc_req_i) begin
          if (sel1.memory_kind_sel == KIND_ASYNC16 ||
              (sel1.memory_kind_sel == KIND_ASYNC8 &&
               !acc_i.write)) begin // RULE_02 RULE_03
            start   = 1'b1;
            state_d = ST_SETUP; // RULE_20
            if (acc_i.write) begin
              cnt_d = setup_len(sel2.write_setup_cycles,
                                acc_i.first) - 6'h01; // RULE_11 RULE_19
            end else begin
              cnt_d = setup_len(sel1.read_setup_cycles,
                                acc_i.first) - 6'h01; // RULE_04 RULE_19
            end
          end else if (sel1.memory_kind_sel == KIND_ASYNC8) begin
            refuse_wr8 = 1'b1; // RULE_03
          end else begin
            refuse_kind = 1'b1; // RULE_02 RULE_18
          end
        end
      end
      ST_SETUP: begin
        if (cnt_q == 6'h00) begin
          state_d = ST_STROBE;
          cnt_d   = write_q
                  ? strobe_len(cur2_q.write_strobe_cycles) - 6'h01 // RULE_12
                  : strobe_len(cur1_q.read_strobe_cycles) - 6'h01; // RULE_05
        end else begin
          cnt_d = cnt_q - 6'h01;
        end
      end
      ST_STROBE: begin
        // The programmed strobe runs out before ready can stretch it.
        if (tmo_hit) begin
          ext_d   = 1'b1;
          state_d = ST_HOLD;
          cnt_d   = hold_len - 6'h01;
        end else if (cnt_q != 6'h00) begin
          cnt_d = cnt_q - 6'h01;
        end else if (!ready) begin
          ext_d = 1'b1; // RULE_17
        end else if (hold_len != 6'h00) begin
          state_d = ST_HOLD;
          cnt_d   = hold_len - 6'h01;
        end else begin
          state_d = ST_EXHOLD;
          cnt_d   = {4'h0, exh_raw}; // RULE_09 RULE_10
        end
      end
      ST_HOLD: begin
        if (cnt_q == 6'h00) begin
          state_d = ST_EXHOLD;
          cnt_d   = {4'h0, exh_raw}; // RULE_09 RULE_10
        end else begin
          cnt_d = cnt_q - 6'h01;
        end
      end
      ST_EXHOLD: begin
        if (cnt_q == 6'h00) begin
          state_d = ST_IDLE;
          finish  = 1'b1;
        end else begin
          cnt_d = cnt_q - 6'h01;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      cnt_q   <= 6'h00;
      ext_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ext_q   <= ext_d;
    end
  end

  // Fields are captured at the start so a write mid-access is harmless.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      write_q <= 1'b0;
      space_q <= '0;
      cur1_q  <= RST_TYPE_READ;
      cur2_q  <= RST_WRITE;
      limit_q <= 8'h00;
    end else if (start) begin
      write_q <= acc_i.write;
      space_q <= acc_i.space;
      cur1_q  <= sel1;
      cur2_q  <= sel2;
      limit_q <= ctl3_q[acc_i.space].ready_wait_limit;
    end
  end

  // ****************************************************************
  // Ready wait limit
  // ****************************************************************
  assign tmo_hit = (state_q != ST_IDLE) && (limit_q != 8'h00) &&
                   !ready && !tmo_seen_q &&
                   (8'(tmo_cnt_q + 8'h01) == limit_q); // RULE_15 RULE_16

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tmo_cnt_q  <= 8'h00;
      tmo_seen_q <= 1'b0;
    end else if (start) begin
      tmo_cnt_q  <= 8'h00;
      tmo_seen_q <= 1'b0;
    end else if (state_q != ST_IDLE) begin
      if (!ready && !tmo_seen_q) begin
        tmo_cnt_q <= 8'(tmo_cnt_q + 8'h01); // RULE_16
      end
      if (tmo_hit) begin
        tmo_seen_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  logic [NUM_SPACES-1:0] stat_tmo_q;
  logic                  stat_wr8_q;
  logic                  stat_kind_q;
  logic                  stat_clr;

  assign stat_clr = reg_wr_i && (reg_addr_i == ADDR_STATUS);

  // Write one to clear; a fresh event in the same cycle wins.
  for (genvar s = 0; s < NUM_SPACES; s++) begin : g_stat
    always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
        stat_tmo_q[s] <= 1'b0;
      end else begin
        stat_tmo_q[s] <= (stat_tmo_q[s] &
                          ~(stat_clr & reg_wdata_i[STAT_TMO_LSB + s])) |
                         (tmo_hit && (space_q == SPACE_W'(s))); // RULE_16
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stat_wr8_q  <= 1'b0;
      stat_kind_q <= 1'b0;
    end else begin
      stat_wr8_q  <= (stat_wr8_q & ~(stat_clr & reg_wdata_i[STAT_WR8_BIT]))
                     | refuse_wr8;
      stat_kind_q <= (stat_kind_q &
                      ~(stat_clr & reg_wdata_i[STAT_KIND_BIT]))
                     | refuse_kind;
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata_o <= 16'h0000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_addr_i == ADDR_STATUS) begin
      reg_rdata_o <= 16'h0000;
      reg_rdata_o[STAT_TMO_LSB +: NUM_SPACES] <= stat_tmo_q;
      reg_rdata_o[STAT_WR8_BIT]  <= stat_wr8_q;
      reg_rdata_o[STAT_KIND_BIT] <= stat_kind_q;
      reg_rdata_o[STAT_BUSY_BIT] <= (state_q != ST_IDLE);
    end else if (!reg_addr_i[4] && reg_addr_i[1:0] == OFS_TYPE_READ) begin
      reg_rdata_o <= ctl1_q[reg_addr_i[3:2]]; // RULE_01
    end else if (!reg_addr_i[4] && reg_addr_i[1:0] == OFS_WRITE) begin
      reg_rdata_o <= ctl2_q[reg_addr_i[3:2]];
    end else if (!reg_addr_i[4] && reg_addr_i[1:0] == OFS_TIMEOUT) begin
      reg_rdata_o <= ctl3_q[reg_addr_i[3:2]]; // RULE_14
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      acc_busy_o <= 1'b0;
      acc_done_o <= 1'b0;
      acc_err_o  <= 1'b0;
      mem_cs_n_o <= 1'b1;
      mem_oe_n_o <= 1'b1;
      mem_we_n_o <= 1'b1;
      mem_wide_o <= 1'b0;
    end else begin
      acc_busy_o <= (state_d != ST_IDLE);
      acc_done_o <= finish | refuse_wr8 | refuse_kind;
      acc_err_o  <= (finish & (tmo_seen_q | tmo_hit)) |
                    refuse_wr8 | refuse_kind;
      mem_cs_n_o <= !(state_d == ST_SETUP || state_d == ST_STROBE ||
                      state_d == ST_HOLD);
      mem_oe_n_o <= !(state_d == ST_STROBE && !(start ? acc_i.write
                                                      : write_q));
      mem_we_n_o <= !(state_d == ST_STROBE && (start ? acc_i.write
                                                     : write_q));
      mem_wide_o <= start ? (sel1.memory_kind_sel == KIND_ASYNC16)
                          : (mem_wide_o & (state_d != ST_IDLE));
    end
  end

endmodule // amstc_top

// ===== logic/amstc_pkg.sv
// Function
// [RULE_01] Control one top bit reads zero, ignores writes
// [RULE_02] Memory kind decode: 8-bit, 16-bit, SDRAM
// [RULE_03] Eight-bit async memory allows reads only
// [RULE_04] Read setup: 0..2 gives 1, else n
// [RULE_05] Read strobe: 0..1 gives 1, else n
// [RULE_06] Read hold lasts exactly n cycles
// [RULE_07] Ready-lengthened read strobe forces hold one
// [RULE_08] Ready-lengthened write strobe forces hold one
// [RULE_09] Read extended hold lasts n plus one
// [RULE_10] Write extended hold lasts n plus one
// [RULE_11] Write setup: 0..2 gives 1, else n
// [RULE_12] Write strobe: 0..1 gives 1, else n
// [RULE_13] Write hold lasts exactly n cycles
// [RULE_14] Control three upper byte reads zero
// [RULE_15] Wait limit resets zero; zero disables it
// [RULE_16] Count ready-low cycles; flag error at limit
// [RULE_17] Memory holds ready low to stretch strobe
// [RULE_18] Synchronous kind ignores timing and limit fields
// [RULE_19] First access setup lasts at least two
// [RULE_20] Sequence setup, strobe, hold, extended hold
package amstc_pkg;

  // ****************************************************************
  // Sizes and map
  // ****************************************************************
  localparam int          NUM_SPACES    = 4;
  localparam int          SPACE_W       = 2;
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 16;
  localparam logic [1:0]  OFS_TYPE_READ = 2'h0;
  localparam logic [1:0]  OFS_WRITE     = 2'h1;
  localparam logic [1:0]  OFS_TIMEOUT   = 2'h2;
  localparam logic [4:0]  ADDR_STATUS   = 5'h10;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] RST_TYPE_READ = 16'h2FFF;
  localparam logic [15:0] RST_WRITE     = 16'h5FFF;
  localparam logic [15:0] RST_TIMEOUT   = 16'h0000;

  // ****************************************************************
  // Memory kinds and period limits
  // ****************************************************************
  localparam logic [2:0]  KIND_ASYNC8   = 3'h0;
  localparam logic [2:0]  KIND_ASYNC16  = 3'h1;
  localparam logic [2:0]  KIND_SDRAM    = 3'h3;
  localparam logic [3:0]  SETUP_FLOOR   = 4'h2;
  localparam logic [5:0]  STROBE_FLOOR  = 6'h01;
  localparam logic [5:0]  MIN_PERIOD    = 6'h01;
  localparam logic [5:0]  FIRST_SETUP   = 6'h02;

  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int          STAT_TMO_LSB  = 0;
  localparam int          STAT_WR8_BIT  = 4;
  localparam int          STAT_KIND_BIT = 5;
  localparam int          STAT_BUSY_BIT = 8;

  typedef struct packed {
    logic       rsv;
    logic [2:0] memory_kind_sel;
    logic [3:0] read_setup_cycles;
    logic [5:0] read_strobe_cycles;
    logic [1:0] read_hold_cycles;
  } amstc_ctl1_s;

  typedef struct packed {
    logic [1:0] read_extra_hold_cycles;
    logic [1:0] write_extra_hold_cycles;
    logic [3:0] write_setup_cycles;
    logic [5:0] write_strobe_cycles;
    logic [1:0] write_hold_cycles;
  } amstc_ctl2_s;

  typedef struct packed {
    logic [7:0] rsv;
    logic [7:0] ready_wait_limit;
  } amstc_ctl3_s;

  typedef struct packed {
    logic [SPACE_W-1:0] space;
    logic               write;
    logic               first;
  } amstc_req_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_EXHOLD
  } amstc_state_e;

endpackage

// ===== logic/amstc_in_sync.sv
`timescale 1ns/1ns
module amstc_in_sync
  import amstc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Pin and filtered level
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_q <= 1'b1;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level_o = level_q;

endmodule // amstc_in_sync

// ===== testbench/amstc_top_asserts.sv
`timescale 1ns/1ns
module amstc_top_asserts
  import amstc_pkg::*;
(
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              nrst_i,
  // Register port
  input wire logic              reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // Access port
  input wire logic              acc_req_i,
  input wire logic              acc_busy_o,
  input wire logic              acc_done_o,
  input wire logic              acc_err_o,
  // Memory pins
  input wire logic              mem_cs_n_o,
  input wire logic              mem_oe_n_o,
  input wire logic              mem_we_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_strobe_excl: assert property (mem_oe_n_o || mem_we_n_o)
    else $error("read and write strobes low together");
  a_strobe_in_cs: assert property (
    !(mem_oe_n_o && mem_we_n_o) |-> !mem_cs_n_o)
    else $error("strobe outside chip select");
  a_req_answer: assert property (
    acc_req_i && !acc_busy_o && !acc_done_o |=> acc_busy_o || acc_done_o)
    else $error("idle request got no answer");
  a_setup_first: assert property (
    $fell(mem_cs_n_o) |-> mem_oe_n_o && mem_we_n_o)
    else $error("strobe without setup cycle");
  a_exhold_busy: assert property (
    $rose(mem_cs_n_o) |-> acc_busy_o && !acc_done_o)
    else $error("no extended hold after select");
  a_done_idle: assert property (acc_done_o |-> !acc_busy_o)
    else $error("busy during done");
  a_busy_ends: assert property ($fell(acc_busy_o) |-> acc_done_o)
    else $error("busy ended without done");
  a_err_done: assert property (acc_err_o |-> acc_done_o)
    else $error("error without done");
  a_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == '0)
    else $error("read data outside read slot");

  c_err: cover property (acc_done_o && acc_err_o);
  c_read: cover property ($fell(mem_oe_n_o));
  c_write: cover property ($fell(mem_we_n_o));
endmodule // amstc_top_asserts

// ===== testbench/amstc_mem_model.sv
`timescale 1ns/1ns
module amstc_mem_model (
  // Clock
  input  wire logic       clk_i,
  // Memory pins
  input  wire logic       cs_n_i,
  input  wire logic       strobe_n_i,
  input  wire logic [7:0] stall_i,
  output logic            ready_o
);
  logic [7:0] left_q;
  logic       act_q;

  always @(posedge clk_i) begin
    if (cs_n_i) begin
      act_q  <= 1'b0;
      left_q <= 8'h00;
    end else if (!strobe_n_i && !act_q) begin
      act_q  <= 1'b1;
      left_q <= stall_i;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  // Ready is pulled high while deselected; low while the access stalls.
  assign ready_o = cs_n_i || (left_q == 8'h00);
endmodule // amstc_mem_model

// ===== testbench/tb_async_mem_space_timing_cfg.sv
`timescale 1ns/1ns
module tb_async_mem_space_timing_cfg;
  import amstc_pkg::*;
  logic              clk_i, nrst_i, reg_wr_i, reg_rd_i, acc_req_i, rdy;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
  amstc_req_s        acc_i;
  logic              acc_busy_o, acc_done_o, acc_err_o, mem_wide_o;
  logic              mem_cs_n_o, mem_oe_n_o, mem_we_n_o;
  logic [7:0]        stall;
  int                error_cnt, n_checks;

  amstc_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .acc_req_i(acc_req_i), .acc_i(acc_i),
    .acc_busy_o(acc_busy_o), .acc_done_o(acc_done_o),
    .acc_err_o(acc_err_o), .memory_ready_in_i(rdy),
    .mem_cs_n_o(mem_cs_n_o), .mem_oe_n_o(mem_oe_n_o),
    .mem_we_n_o(mem_we_n_o), .mem_wide_o(mem_wide_o));

  amstc_mem_model u_mem (.clk_i(clk_i), .cs_n_i(mem_cs_n_o),
    .strobe_n_i(mem_oe_n_o & mem_we_n_o), .stall_i(stall), .ready_o(rdy));

  // ****************************************************************
  // Checks and bus tasks
  // ****************************************************************
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // Measures the phases of one access from the memory pins.
  task automatic acc(logic [1:0] s, logic w, logic f, output int su, st,
                     ho, eh, output logic er, wd);
    int ph, n;
    su = 0; st = 0; ho = 0; eh = 0; ph = 0; er = 0; wd = 0;
    @(posedge clk_i);
    acc_req_i <= 1'b1;
    acc_i     <= '{s, w, f};
    @(posedge clk_i);
    acc_req_i <= 1'b0;
    for (n = 0; n < 2000; n++) begin
      #1;
      if (acc_done_o === 1'b1) begin
        er = acc_err_o;
        break;
      end
      wd |= mem_wide_o;
      if (!(mem_oe_n_o & mem_we_n_o)) begin
        ph = 1;
        st++;
      end else if (!mem_cs_n_o) begin
        if (ph == 0) su++;
        else ho++;
      end else if (ph != 0) eh++;
      @(posedge clk_i);
    end
    if (n == 2000) begin
      error_cnt++;
      complete_run;
    end
  endtask

  function automatic logic [15:0] su_e(logic [3:0] f, logic first);
    if (f > 4'h2) return {12'h000, f};
    return first ? 16'h0002 : 16'h0001;
  endfunction

  function automatic logic [15:0] st_e(logic [5:0] f);
    return (f > 6'h01) ? {10'h000, f} : 16'h0001;
  endfunction

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [15:0] d, e, c1, c2;
    logic [1:0]  s;
    logic        er, wd, w, f;
    int          su, st, ho, eh;
    nrst_i = 0; reg_wr_i = 0; reg_rd_i = 0; reg_addr_i = '0;
    reg_wdata_i = '0; acc_req_i = 0; acc_i = '0; stall = 8'h00;
    error_cnt = 0; n_checks = 0;
    d = $urandom(48700);
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 16; i++) begin
      e = (i % 4 == 0) ? RST_TYPE_READ : (i % 4 == 1) ? RST_WRITE :
          (i % 4 == 2) ? RST_TIMEOUT : 16'h0000;
      rd(5'(i), d);
      chk("reset value", e, d);
      wr(5'(i), 16'hFFFF);
      rd(5'(i), d);
      e = (i % 4 == 0) ? 16'h7FFF : (i % 4 == 1) ? 16'hFFFF :
          (i % 4 == 2) ? 16'h00FF : 16'h0000;
      chk("read-only bits", e, d);
      if (i % 4 == 2) wr(5'(i), 16'h0000);
    end
    for (int k = 0; k < 8; k++) begin
      wr(5'h04, {1'b0, 3'(k), 12'h000});
      acc(2'h1, 1'b0, 1'b0, su, st, ho, eh, er, wd);
      chk("kind refused", {15'h0, k > 1}, {15'h0, er});
      chk("wide pin", {15'h0, k == 1}, {15'h0, wd});
    end
    wr(5'h04, 16'h0000);
    acc(2'h1, 1'b1, 1'b0, su, st, ho, eh, er, wd);
    chk("narrow write", 16'h0001, {15'h0, er});
    rd(ADDR_STATUS, d);
    chk("status narrow", 16'h0001, {15'h0, d[STAT_WR8_BIT]});
    chk("status kind", 16'h0001, {15'h0, d[STAT_KIND_BIT]});
    wr(ADDR_STATUS, 16'h003F);
    for (int i = 0; i < 14; i++) begin
      s = 2'($urandom);
      c1 = {4'h1, 12'($urandom)};
      c2 = 16'($urandom);
      w = 1'($urandom);
      f = 1'($urandom);
      if (i == 0) begin
        c1 = 16'h1000;
        c2 = 16'h0000;
        f = 1'b1;
      end
      if (i == 1) begin
        c1 = 16'h1FFF;
        c2 = 16'hFFFF;
      end
      wr({1'b0, s, 2'h0}, c1);
      wr({1'b0, s, 2'h1}, c2);
      acc(s, w, f, su, st, ho, eh, er, wd);
      e = su_e(w ? c2[11:8] : c1[11:8], f);
      chk("setup", e, 16'(su));
      chk("strobe", st_e(w ? c2[7:2] : c1[7:2]), 16'(st));
      chk("hold", {14'h0, w ? c2[1:0] : c1[1:0]}, 16'(ho));
      e = {14'h0, w ? c2[13:12] : c2[15:14]} + 16'h1;
      chk("exhold", e, 16'(eh));
      chk("no error", 16'h0000, {15'h0, er});
    end
    wr(5'h00, 16'h1318);
    wr(5'h01, 16'h0318);
    stall = 8'h0A;
    for (int k = 0; k < 2; k++) begin
      acc(2'h0, k[0], 1'b0, su, st, ho, eh, er, wd);
      chk("stretched", 16'h0001, {15'h0, st > 6});
      chk("forced hold", 16'h0001, 16'(ho));
    end
    wr(5'h02, 16'h0005);
    stall = 8'h28;
    acc(2'h0, 1'b0, 1'b0, su, st, ho, eh, er, wd);
    chk("timeout error", 16'h0001, {15'h0, er});
    rd(ADDR_STATUS, d);
    chk("timeout flag", 16'h0001, {15'h0, d[STAT_TMO_LSB]});
    wr(5'h02, 16'h0000);
    acc(2'h0, 1'b1, 1'b0, su, st, ho, eh, er, wd);
    chk("limit off", 16'h0000, {15'h0, er});
    complete_run;
  end
endmodule // tb_async_mem_space_timing_cfg

bind amstc_top amstc_top_asserts u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .acc_req_i(acc_req_i),
  .acc_busy_o(acc_busy_o), .acc_done_o(acc_done_o),
  .acc_err_o(acc_err_o), .mem_cs_n_o(mem_cs_n_o),
  .mem_oe_n_o(mem_oe_n_o), .mem_we_n_o(mem_we_n_o));
